// ### design/disk_ctrl_param_timing.sv
// Purpose: Interprets floppy command parameters into drive behaviour
// Assumes: 100 MHz clock, drive inputs synchronous, one byte tick per
//          disk byte on BYTE_TICK_IN
// Notes:   Registers reached over Avalon-MM with waitrequest
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "disk_param_regs.svh"

// Notes on behaviour
// RULE1 - Record code 0..6 selects 128..8192 bytes
// RULE2 - Access runs start sector through end sector
// RULE3 - Transfer end input stops access at once
// RULE4 - Host keeps end sector legal, compare 253
// RULE5 - Partial count only for code 0, max 128
// RULE6 - Gap skip bytes passed between sectors
// RULE7 - Format writes count sectors, gaps, fill byte
// RULE8 - Compare advances sector by stride
// RULE9 - Seek steps head toward target cylinder
// RULE10 - Timing byte splits step and unload nibbles
// RULE11 - Step interval 16 minus code, doubled
// RULE12 - Head unload after code times 16/32 ms
// RULE13 - Second byte gives load code, PIO select
// RULE14 - Head load wait code times 2/4 ms
// RULE15 - Low current above threshold, never at zero
// RULE16 - Precomp code steps write data delay
// RULE17 - Host keeps precomp codes within limits
// RULE18 - Inner delay at or above switch track
// RULE19 - Seek end flag on seek/recal finish
// RULE20 - Fault flag on write fault or 255 steps
// RULE21 - Unready flag on access with drive unready
// RULE22 - Status shows head/unit, head zero on query
// RULE23 - Top two bits encode interrupt cause
// RULE24 - Timers count device clock cycles
module disk_ctrl_param_timing
  import disk_param_pkg::*;
#(
  parameter int CYCLES_PER_MS = `CYC_PER_MS
) (
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [5:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  input  wire logic        READY_IN,
  input  wire logic        FAULT_IN,
  input  wire logic        TRACK0_IN,
  input  wire logic        BYTE_TICK_IN,
  input  wire logic        TRANSFER_END_IN,
  output logic             HEAD_LOAD_OUT,
  output logic             STEP_OUT,
  output logic             STEP_DIR_OUT,
  output logic             LOW_CURRENT_OUT,
  output logic             PIO_MODE_OUT,
  output logic      [3:0]  PRECOMP_CODE_OUT,
  output logic             XFER_ACTIVE_OUT,
  output logic             GAP_ACTIVE_OUT,
  output logic      [7:0]  SECTOR_OUT,
  output logic      [7:0]  WRITE_BYTE_OUT
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    state_t      st;
    logic        wait_rq;
    logic [31:0] rdata;
    logic [3:0]  cmd;
    logic [2:0]  sel;
    logic [31:0] sect;
    logic [23:0] gapr;
    logic [23:0] fmt;
    logic [31:0] timing;
    logic [24:0] spec2;
    logic [7:0]  cyl;
    logic [7:0]  cur_cyl;
    logic [7:0]  sector;
    logic [7:0]  fmt_cnt;
    logic [7:0]  step_cnt;
    logic [13:0] byte_left;
    logic [31:0] presc;
    logic [9:0]  ms_left;
    logic        unload_arm;
    logic        busy;
    status_byte_zero_t       status_byte_zero;
    logic        seek_pend;
    logic        rdy_changed;
    logic        rdy_last;
    logic        head_load;
    logic        step;
    logic        dir;
    logic        low_cur;
    logic [3:0]  precomp;
    logic [7:0]  wbyte;
    logic        xfer, gap;
  } regs_t;

  regs_t     r_reg;
  regs_t     r_next;
  drive_in_t drv;

  assign drv = '{ready: READY_IN, fault: FAULT_IN, track0: TRACK0_IN,
                 byte_tick: BYTE_TICK_IN, transfer_end: TRANSFER_END_IN};

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // RULE1 size decode
  // RULE5 partial count clamp
  function automatic logic [13:0] sect_bytes(input logic [2:0] rl,
                                             input logic [7:0] part);
    logic [2:0] c;
    c = (rl > 3'h6) ? 3'h6 : rl;  // Code 7 is unused, held at largest
    if (c == 3'h0)
      sect_bytes = (part > 8'h80) ? 14'h0080 : {6'h00, part};
    else
      sect_bytes = 14'h0080 << c;
  endfunction

  // RULE24 ms per code step
  function automatic logic [9:0] ms_scale(input logic [6:0] code,
                                          input logic [5:0] unit);
    ms_scale = {3'h0, code} * {4'h0, unit};
  endfunction

  logic [7:0] s_start, s_end, part, gap_skip, stride;
  logic [7:0] f_count, f_gap, f_fill;
  logic [3:0] step_code, unload_code;
  logic [6:0] load_code;
  logic       eight, hseek, spec2_on, auto_pc, tick_ms;
  logic [4:0] step_ms;

  // RULE10 timing byte split
  // RULE13 load code and PIO
  always_comb begin
    s_start     = r_reg.sect[7:0];
    s_end       = r_reg.sect[15:8];
    part        = r_reg.gapr[15:8];
    gap_skip    = r_reg.gapr[7:0];
    stride      = r_reg.gapr[23:16];
    f_count     = r_reg.fmt[7:0];
    f_gap       = r_reg.fmt[15:8];
    f_fill      = r_reg.fmt[23:16];
    step_code   = r_reg.timing[7:4];
    unload_code = r_reg.timing[3:0];
    load_code   = r_reg.timing[15:9];
    eight       = r_reg.timing[`TIME_EIGHT_BIT];
    spec2_on    = r_reg.timing[`TIME_SPEC2_BIT];
    hseek       = r_reg.timing[`TIME_HSEEK_BIT] & spec2_on;
    auto_pc     = r_reg.spec2[`SPEC2_AUTO_BIT] & spec2_on;
    tick_ms     = (r_reg.presc >= 32'(CYCLES_PER_MS - 1));
    // RULE11 step interval
    step_ms     = 5'(`STEP_BASE_MS) - {1'b0, step_code};
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic is_access, is_write, last;
    logic [1:0] fin_code;
    r_next = r_reg;
    is_access = 1'b0;
    is_write = (r_reg.cmd == `CMD_WRITE) || (r_reg.cmd == `CMD_FORMAT);
    last = 1'b0;
    fin_code = `INT_NORMAL;
    r_next.step = 1'b0;
    // Bus answer: one wait cycle, then the access completes
    r_next.wait_rq = 1'b1;
    if ((AVS_READ_IN || AVS_WRITE_IN) && r_reg.wait_rq) begin
      r_next.wait_rq = 1'b0;
      case (AVS_ADDRESS_IN)
        `OFS_SEL:    r_next.rdata = {29'h0, r_reg.sel};
        `OFS_SECT:   r_next.rdata = r_reg.sect;
        `OFS_GAP:    r_next.rdata = {8'h00, r_reg.gapr};
        `OFS_FMT:    r_next.rdata = {8'h00, r_reg.fmt};
        `OFS_TIME:   r_next.rdata = r_reg.timing;
        `OFS_SPEC2:  r_next.rdata = {7'h00, r_reg.spec2};
        `OFS_CYL:    r_next.rdata = {24'h0, r_reg.cyl};
        `OFS_STATUS: r_next.rdata = {r_reg.sector, r_reg.cur_cyl,
                                     7'h00, r_reg.busy, r_reg.status_byte_zero};
        default:     r_next.rdata = 32'h0;  // Unmapped reads as zero
      endcase
    end
    if (AVS_WRITE_IN && !r_reg.wait_rq) begin
      case (AVS_ADDRESS_IN)
        `OFS_CMD:   if (!r_reg.busy) begin
          r_next.cmd  = AVS_WRITEDATA_IN[3:0];
          r_next.busy = 1'b1;
        end
        `OFS_SEL:   r_next.sel    = AVS_WRITEDATA_IN[2:0];
        `OFS_SECT:  r_next.sect   = AVS_WRITEDATA_IN;
        `OFS_GAP:   r_next.gapr   = AVS_WRITEDATA_IN[23:0];
        `OFS_FMT:   r_next.fmt    = AVS_WRITEDATA_IN[23:0];
        `OFS_TIME:  r_next.timing = AVS_WRITEDATA_IN;
        `OFS_SPEC2: r_next.spec2  = AVS_WRITEDATA_IN[24:0];
        `OFS_CYL:   r_next.cyl    = AVS_WRITEDATA_IN[7:0];
        default:    ;
      endcase
    end
    // RULE24 shared ms prescaler
    r_next.presc = tick_ms ? 32'h0 : r_reg.presc + 32'h1;
    if (tick_ms && r_reg.ms_left != 10'h0)
      r_next.ms_left = r_reg.ms_left - 10'h1;

    case (r_reg.st)
      S_IDLE: begin
        // RULE12 head unload delay
        if (r_reg.unload_arm && r_reg.ms_left == 10'h0) begin
          r_next.head_load  = 1'b0;
          r_next.unload_arm = 1'b0;
        end
        if (r_reg.busy && r_reg.cmd == r_next.cmd) begin
          r_next.status_byte_zero = '{irq_cause_code: `INT_NORMAL, head_sel: r_reg.sel[2],
                          unit_sel_hi: r_reg.sel[1], unit_sel_lo: r_reg.sel[0],
                          default: 1'b0};
          case (r_reg.cmd)
            `CMD_SEEK, `CMD_RECAL: begin
              r_next.step_cnt = 8'h00;
              r_next.st = S_SEEK;
            end
            `CMD_READ, `CMD_WRITE, `CMD_FORMAT, `CMD_COMPARE: begin
              is_access = 1'b1;
            end
            `CMD_IRQ_QRY: begin
              r_next.busy = 1'b0;
              // RULE22 head bit zero
              // RULE23 ready change code
              if (r_reg.rdy_changed) begin
                r_next.status_byte_zero.irq_cause_code = `INT_READY_CHG;
                r_next.status_byte_zero.head_sel = 1'b0;
                r_next.rdy_changed = 1'b0;
              end else if (r_reg.seek_pend) begin
                r_next.status_byte_zero = r_reg.status_byte_zero;
                r_next.status_byte_zero.head_sel = 1'b0;
                r_next.seek_pend = 1'b0;
              end else begin
                r_next.status_byte_zero = '{irq_cause_code: `INT_INVALID, default: 1'b0};
              end
            end
            `CMD_DEV_STAT: r_next.busy = 1'b0;
            default: begin
              r_next.busy = 1'b0;
              r_next.status_byte_zero = '{irq_cause_code: `INT_INVALID, default: 1'b0};
            end
          endcase
        end
        // RULE21 unready at start
        if (is_access && !drv.ready) begin
          r_next.status_byte_zero.irq_cause_code = `INT_ABNORMAL;
          r_next.status_byte_zero.drive_unready_flag = 1'b1;
          r_next.busy = 1'b0;
        end else if (is_access) begin
          r_next.unload_arm = 1'b0;
          r_next.head_load  = 1'b1;
          // RULE14 head load wait
          r_next.ms_left = r_reg.head_load ? 10'h0 :
            ms_scale(load_code, eight ? 6'(`LOAD_8_MS) : 6'(`LOAD_5_MS));
          r_next.presc = 32'h0;
          r_next.st = S_LOAD;
        end
      end
      S_LOAD: begin
        if (r_reg.ms_left == 10'h0) begin
          // RULE2 start sector
          // RULE7 format begins at one
          r_next.sector  = (r_reg.cmd == `CMD_FORMAT) ? 8'h01 : s_start;
          r_next.fmt_cnt = 8'h01;
          r_next.byte_left = sect_bytes(r_reg.sect[18:16], part);
          r_next.st = S_DATA;
        end
      end
      S_SEEK: begin
        // RULE9 step toward target
        // RULE20 recal step limit
        if (r_reg.cmd == `CMD_RECAL && drv.track0) begin
          r_next.cur_cyl = 8'h00;
          last = 1'b1;
        end else if (r_reg.cmd == `CMD_RECAL &&
                     r_reg.step_cnt == `MAX_STEPS) begin
          r_next.status_byte_zero.drive_fault_flag = 1'b1;
          fin_code = `INT_ABNORMAL;
          last = 1'b1;
        end else if (r_reg.cmd == `CMD_SEEK && r_reg.cur_cyl == r_reg.cyl) begin
          last = 1'b1;
        end else begin
          r_next.dir  = (r_reg.cmd == `CMD_SEEK) &&
                        (r_reg.cyl > r_reg.cur_cyl);
          r_next.step = 1'b1;
          r_next.step_cnt = r_reg.step_cnt + 8'h01;
          if (r_reg.cmd == `CMD_SEEK)
            r_next.cur_cyl = (r_reg.cyl > r_reg.cur_cyl) ?
              r_reg.cur_cyl + 8'h01 : r_reg.cur_cyl - 8'h01;
          // RULE11 doubled in slow mode unless hseek is set
          r_next.ms_left = (eight || hseek) ? {5'h00, step_ms} :
                                              {4'h0, step_ms, 1'b0};
          r_next.presc = 32'h2;  // Covers decision cycles
          r_next.st = S_STEPW;
        end
        // RULE19 seek end flag
        if (last) begin
          r_next.status_byte_zero.seek_done_flag = 1'b1;
          r_next.status_byte_zero.irq_cause_code = fin_code;
          r_next.seek_pend = 1'b1;
          r_next.busy = 1'b0;
          r_next.st = S_IDLE;
        end
      end
      S_STEPW: if (r_reg.ms_left == 10'h0) r_next.st = S_SEEK;
      S_DATA, S_GAP: begin
        if (drv.byte_tick && r_reg.byte_left != 14'h0)
          r_next.byte_left = r_reg.byte_left - 14'h1;
        if (r_reg.st == S_DATA && r_reg.byte_left == 14'h0) begin
          // RULE6 skip gap
          // RULE7 format gap length
          r_next.byte_left = {6'h00,
            (r_reg.cmd == `CMD_FORMAT) ? f_gap : gap_skip};
          r_next.st = S_GAP;
        end
        if (r_reg.st == S_GAP && r_reg.byte_left == 14'h0) begin
          // RULE2 end sector
          // RULE7 sector count
          if (r_reg.cmd == `CMD_FORMAT) last = (r_reg.fmt_cnt >= f_count);
          else last = (r_reg.sector >= s_end);
          // RULE8 compare stride
          r_next.sector = r_reg.sector +
            ((r_reg.cmd == `CMD_COMPARE) ? stride : 8'h01);
          r_next.fmt_cnt = r_reg.fmt_cnt + 8'h01;
          r_next.byte_left = sect_bytes(r_reg.sect[18:16], part);
          r_next.st = S_DATA;
        end
        // RULE3 end on transfer end
        if (drv.transfer_end) last = 1'b1;
        // RULE21 unready during access
        if (!drv.ready) begin
          r_next.status_byte_zero.drive_unready_flag = 1'b1;
          fin_code = `INT_ABNORMAL;
          last = 1'b1;
        end
        // RULE20 write fault
        if (is_write && drv.fault) begin
          r_next.status_byte_zero.drive_fault_flag = 1'b1;
          fin_code = `INT_ABNORMAL;
          last = 1'b1;
        end
        if (last) begin
          r_next.status_byte_zero.irq_cause_code = fin_code;
          r_next.busy = 1'b0;
          r_next.unload_arm = 1'b1;
          r_next.ms_left = ms_scale({3'h0, unload_code},
            eight ? 6'(`UNLOAD_8_MS) : 6'(`UNLOAD_5_MS));
          r_next.presc = 32'h0;
          r_next.st = S_IDLE;
        end
      end
      default: r_next.st = S_IDLE;
    endcase
    // Ready level change latch; a new change wins over a query clear
    if (drv.ready != r_reg.rdy_last) begin
      r_next.rdy_changed = 1'b1;
      r_next.rdy_last = drv.ready;
    end
    // RULE15 low current track
    r_next.low_cur = spec2_on && (r_reg.spec2[7:0] != 8'h00) &&
                     (r_next.cur_cyl > r_reg.spec2[7:0]);
    // RULE16 precomp step code
    // RULE18 inner or outer delay
    r_next.precomp = !auto_pc ? 4'h0 :
      (r_next.cur_cyl >= r_reg.spec2[23:16]) ? r_reg.spec2[15:12]
                                              : r_reg.spec2[11:8];
    r_next.wbyte = (r_next.st == S_DATA && r_reg.cmd == `CMD_FORMAT) ?
                   f_fill : 8'h00;
    r_next.xfer = (r_next.st == S_DATA);
    r_next.gap  = (r_next.st == S_GAP);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.wait_rq <= 1'b1;
      r_reg.timing <= `RST_TIME;
      r_reg.gapr <= {`RST_STRIDE, 16'h0000};
      r_reg.rdy_last <= 1'b1;  // Idle drive taken as ready after reset
    end else begin
      r_reg <= r_next;
    end
  end

  assign AVS_READDATA_OUT    = r_reg.rdata;
  assign AVS_WAITREQUEST_OUT = r_reg.wait_rq;
  assign HEAD_LOAD_OUT       = r_reg.head_load;
  assign STEP_OUT            = r_reg.step;
  assign STEP_DIR_OUT        = r_reg.dir;
  assign LOW_CURRENT_OUT     = r_reg.low_cur;
  assign PIO_MODE_OUT        = r_reg.timing[8];
  assign PRECOMP_CODE_OUT    = r_reg.precomp;
  assign XFER_ACTIVE_OUT     = r_reg.xfer;
  assign GAP_ACTIVE_OUT      = r_reg.gap;
  assign SECTOR_OUT          = r_reg.sector;
  assign WRITE_BYTE_OUT      = r_reg.wbyte;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_step_one_cycle: assert property (STEP_OUT |=> !STEP_OUT) // RULE9
    else $error("step pulse longer than one cycle");
  a_lowcur_zero: assert property ( // RULE15
    (r_reg.spec2[7:0] == 8'h00) && $stable(r_reg.spec2) |=> !LOW_CURRENT_OUT)
    else $error("low current active with zero threshold");
  a_xfer_end_now: assert property ( // RULE3
    (r_reg.st == S_DATA || r_reg.st == S_GAP) && TRANSFER_END_IN
    |=> r_reg.st == S_IDLE && !r_reg.busy)
    else $error("transfer end did not stop access");
  a_load_before_data: assert property ( // RULE14
    $rose(XFER_ACTIVE_OUT) && $past(r_reg.st) == S_LOAD |-> HEAD_LOAD_OUT)
    else $error("data started with head unloaded");
  a_seek_flag_set: assert property ( // RULE19
    r_reg.st == S_SEEK && r_next.st == S_IDLE |=> r_reg.status_byte_zero.seek_done_flag)
    else $error("seek end flag missing");
  a_recal_limit: assert property ( // RULE20
    r_reg.st == S_SEEK && r_reg.cmd == `CMD_RECAL && !TRACK0_IN &&
    r_reg.step_cnt == 8'hff |=> r_reg.status_byte_zero.drive_fault_flag)
    else $error("fault flag missing after 255 steps");
  a_unready_start: assert property ( // RULE21
    r_reg.st == S_IDLE && r_reg.busy && !READY_IN &&
    r_reg.cmd == `CMD_READ |=> r_reg.status_byte_zero.drive_unready_flag)
    else $error("unready flag missing");
  a_query_head_zero: assert property ( // RULE22
    r_reg.st == S_IDLE && r_reg.busy && r_reg.cmd == `CMD_IRQ_QRY
    |=> !r_reg.status_byte_zero.head_sel)
    else $error("head bit set in query answer");
  a_bus_wait_once: assert property (
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
    |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
    else $error("wait request not one cycle");
  a_precomp_inner: assert property ( // RULE18
    auto_pc && $stable(r_reg.spec2) && $stable(r_reg.timing) &&
    r_reg.cur_cyl >= r_reg.spec2[23:16] |-> PRECOMP_CODE_OUT ==
    r_reg.spec2[15:12])
    else $error("inner precomp code not selected");

  c_seek_done: cover property (r_reg.st == S_SEEK ##1 r_reg.st == S_IDLE);
  c_gap_pass:  cover property (GAP_ACTIVE_OUT ##1 XFER_ACTIVE_OUT);
  c_unload:    cover property ($fell(HEAD_LOAD_OUT));
endmodule

// ### design/disk_param_pkg.sv
// Purpose: Types shared by the parameter interpreter
// Assumes: Constants come from disk_param_regs.svh
// Notes:   Types only
package disk_param_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_LOAD, S_SEEK, S_STEPW, S_DATA, S_GAP
  } state_t;

  typedef struct packed {
    logic [1:0] irq_cause_code;
    logic       seek_done_flag;
    logic       drive_fault_flag;
    logic       drive_unready_flag;
    logic       head_sel;
    logic       unit_sel_hi;
    logic       unit_sel_lo;
  } status_byte_zero_t;

  typedef struct packed {
    logic       ready;
    logic       fault;
    logic       track0;
    logic       byte_tick;
    logic       transfer_end;
  } drive_in_t;
endpackage

// ### design/disk_param_regs.svh
// Purpose: Offsets, fields, reset values and timing counts of the block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef DISK_PARAM_REGS_SVH
`define DISK_PARAM_REGS_SVH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_CMD      6'h00
`define OFS_SEL      6'h04
`define OFS_SECT     6'h08
`define OFS_GAP      6'h0c
`define OFS_FMT      6'h10
`define OFS_TIME     6'h14
`define OFS_SPEC2    6'h18
`define OFS_CYL      6'h1c
`define OFS_STATUS   6'h20
// ****************************************************************
// Command codes and field positions
// ****************************************************************
`define CMD_SEEK     4'h1
`define CMD_RECAL    4'h2
`define CMD_READ     4'h3
`define CMD_WRITE    4'h4
`define CMD_FORMAT   4'h5
`define CMD_COMPARE  4'h6
`define CMD_IRQ_QRY  4'h7
`define CMD_DEV_STAT 4'h8
`define TIME_EIGHT_BIT 16
`define TIME_SPEC2_BIT 17
`define TIME_HSEEK_BIT 18
`define SPEC2_AUTO_BIT 24
`define INT_NORMAL   2'h0
`define INT_ABNORMAL 2'h1
`define INT_INVALID  2'h2
`define INT_READY_CHG 2'h3
`define RST_TIME     32'h0000_0000
`define RST_STRIDE   8'h01
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ       100000000
`define MS_PER_SEC   1000
`define CYC_PER_MS   (`CLK_HZ / `MS_PER_SEC)
`define STEP_BASE_MS 16
`define UNLOAD_8_MS  16
`define UNLOAD_5_MS  32
`define LOAD_8_MS    2
`define LOAD_5_MS    4
`define MAX_STEPS    8'hff
`endif

// ### sim/disk_ctrl_param_timing_tb.sv
// Purpose: Self-checking bench for the parameter interpreter
// Assumes: CYCLES_PER_MS of 10, so 1 ms is 10 clocks
// Notes:   Scenarios run in order; cylinder state carries across them
`timescale 1ns/1ps
`include "disk_param_regs.svh"
module disk_ctrl_param_timing_tb;
  logic        clk, rst, rd, wr, tend, rdy_en, flt_en, t0_en, rdy, flt;
  logic        trk0, tick, wreq, hl, stp, sdir, lc, pio, xa, ga, xa_d, hl_d;
  logic [3:0]  pc;
  logic [5:0]  addr;
  logic [7:0]  sec, wb, fill;
  logic [31:0] wdata, rdata, q;
  logic [7:0]  secs[$];
  int          num_errors, checks, cyc, steps, step_gap, last_step;
  int          xlen, glen, wbad, hl_at, xf_at;
  disk_ctrl_param_timing #(.CYCLES_PER_MS(10)) dut_u (
    .CLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq),
    .READY_IN(rdy), .FAULT_IN(flt), .TRACK0_IN(trk0), .BYTE_TICK_IN(tick),
    .TRANSFER_END_IN(tend), .HEAD_LOAD_OUT(hl), .STEP_OUT(stp),
    .STEP_DIR_OUT(sdir), .LOW_CURRENT_OUT(lc), .PIO_MODE_OUT(pio),
    .PRECOMP_CODE_OUT(pc), .XFER_ACTIVE_OUT(xa), .GAP_ACTIVE_OUT(ga),
    .SECTOR_OUT(sec), .WRITE_BYTE_OUT(wb));
  drive_model drv_u (.clk_in(clk), .rst_in(rst), .step_in(stp),
    .dir_in(sdir), .rdy_en_in(rdy_en), .flt_en_in(flt_en),
    .trk0_en_in(t0_en), .ready_out(rdy), .fault_out(flt),
    .track0_out(trk0), .tick_out(tick));
  // Clock of 10 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Monitor: step spacing, sector starts, data and gap lengths
  always @(posedge clk) begin
    cyc++;
    if (stp === 1'b1) begin
      step_gap = cyc - last_step;
      last_step = cyc;
      steps++;
    end
    if (xa === 1'b1 && xa_d !== 1'b1) begin
      if (secs.size() == 0) xf_at = cyc;
      secs.push_back(sec);
    end
    if (xa === 1'b1) xlen++;
    if (xa === 1'b1 && wb !== fill) wbad++;
    if (ga === 1'b1) glen++;
    if (hl === 1'b1 && hl_d !== 1'b1) hl_at = cyc;
    xa_d = xa;
    hl_d = hl;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon cycle: hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    chk(n < 50, 1);
  endtask
  task automatic issue(input logic [3:0] c);
    steps = 0;
    xlen = 0;
    glen = 0;
    wbad = 0;
    secs.delete();
    bus(1'b1, `OFS_CMD, {28'h0, c});
  endtask
  // Poll busy; q then holds the final status word
  task automatic idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end while (q[8] !== 1'b0 && n < 4000);
    chk(n < 4000, 1);
  endtask
  task automatic run(input logic [3:0] c);
    issue(c);
    idle;
  endtask
  task automatic t_reset;
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 6'h24, 32'hffff_ffff);
    bus(1'b0, 6'h24, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `OFS_TIME, 32'h0001_03e1);
    repeat (2) @(posedge clk);
    chk(pio, 1);
  endtask
  task automatic t_seek;
    logic [31:0] tm [3] = '{32'h0001_02e1, 32'h0000_02e1, 32'h0006_02e1};
    int          gp [3] = '{20, 40, 20};
    bus(1'b1, `OFS_SEL, 32'h6);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `OFS_TIME, tm[i]);
      bus(1'b1, `OFS_CYL, 2 * i + 2);
      run(`CMD_SEEK);
      chk(steps, 2);
      chk(step_gap, gp[i]);
      run(`CMD_IRQ_QRY);
      chk(q[7:0], 8'h22);
    end
    run(`CMD_IRQ_QRY);
    chk(q[7:0], 8'h80);
    chk(pio, 0);
  endtask
  task automatic t_precomp;
    logic [7:0] cy [3] = '{8'h06, 8'h04, 8'h05};
    logic [4:0] ex [3] = '{5'h15, 5'h02, 5'h15};
    bus(1'b1, `OFS_TIME, 32'h0003_02e1);
    bus(1'b1, `OFS_SPEC2, 32'h0105_5204);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `OFS_CYL, {24'h0, cy[i]});
      run(`CMD_SEEK);
      chk({lc, pc}, ex[i]);
    end
    bus(1'b1, `OFS_SPEC2, 32'h0105_5200);
    repeat (2) @(posedge clk);
    chk(lc, 0);
  endtask
  task automatic t_recal;
    run(`CMD_RECAL);
    chk(steps, 5);
    run(`CMD_IRQ_QRY);
    chk(q[7:0], 8'h22);
    t0_en <= 1'b0;
    run(`CMD_RECAL);
    chk(steps, 255);
    run(`CMD_IRQ_QRY);
    chk(q[7:0], 8'h72);
    t0_en <= 1'b1;
    bus(1'b1, `OFS_TIME, 32'h0001_02e1);
  endtask
  task automatic t_read;
    logic [31:0] sc [4] = '{32'h0101, 32'h0101, 32'h1_0101, 32'h0402};
    logic [31:0] gp [4] = '{32'h1_9004, 32'h1_1004, 32'h1_1004, 32'h1_8004};
    int          by [4] = '{128, 16, 256, 384};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `OFS_SECT, sc[i]);
      bus(1'b1, `OFS_GAP, gp[i]);
      run(`CMD_READ);
      chk(xlen >= 4 * by[i] - 8 && xlen <= 4 * by[i] + 8, 1);
      chk(secs[0], sc[i][7:0]);
      chk(secs.size(), sc[i][15:8] - sc[i][7:0] + 1);
      chk(xf_at - hl_at >= 20 && xf_at - hl_at <= 28, 1);
      chk(q[7:0], 8'h06);
      if (i == 3) chk(glen >= 24 && glen <= 56, 1);
      repeat (100) @(posedge clk);
      chk(hl, 1);
      repeat (100) @(posedge clk);
      chk(hl, 0);
    end
  endtask
  task automatic t_other;
    int n;
    n = 0;
    bus(1'b1, `OFS_SECT, 32'h0901);
    issue(`CMD_READ);
    while (secs.size() < 2 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    tend <= 1'b1;
    repeat (3) @(posedge clk);
    chk(xa, 0);
    idle;
    tend <= 1'b0;
    chk(secs.size(), 2);
    bus(1'b1, `OFS_FMT, 32'h00a5_0203);
    fill = 8'ha5;
    run(`CMD_FORMAT);
    chk(secs.size(), 3);
    chk(wbad, 0);
    fill = 8'h00;
    bus(1'b1, `OFS_SECT, 32'h0501);
    bus(1'b1, `OFS_GAP, 32'h2_8004);
    run(`CMD_COMPARE);
    chk({secs.size(), secs[1], secs[2]}, {32'd3, 8'h03, 8'h05});
  endtask
  task automatic t_fault;
    flt_en <= 1'b1;
    run(`CMD_WRITE);
    chk(q[7:0], 8'h56);
    flt_en <= 1'b0;
    rdy_en <= 1'b0;
    run(`CMD_READ);
    chk(q[7:0], 8'h4e);
    run(`CMD_DEV_STAT);
    chk(q[3], 0);
    run(`CMD_IRQ_QRY);
    chk(q[7:6], 2'h3);
    rdy_en <= 1'b1;
  endtask
  task automatic final_report;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog well beyond the expected run of some 14000 clocks
  initial begin
    #600000;
    chk(0, 1);
    final_report;
  end
  // Main sequence
  initial begin
    {rst, rdy_en, t0_en} = 3'b111;
    {rd, wr, tend, flt_en, xa_d, hl_d} = 6'h0;
    {addr, wdata, fill} = 46'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_seek;
    t_precomp;
    t_recal;
    t_read;
    t_other;
    t_fault;
    final_report;
  end
endmodule

// ### sim/drive_model.sv
// Purpose: Behavioural floppy drive on the far side of the interpreter
// Assumes: One disk byte passes every fourth clock
// Notes:   Ready, fault and track zero can be broken on bench command
`timescale 1ns/1ps
module drive_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic step_in,
  input  wire logic dir_in,
  input  wire logic rdy_en_in,
  input  wire logic flt_en_in,
  input  wire logic trk0_en_in,
  output logic      ready_out,
  output logic      fault_out,
  output logic      track0_out,
  output logic      tick_out
);
  logic [7:0] cyl_reg;
  logic [1:0] div_reg;
  // Head follows step pulses and cannot go below cylinder zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cyl_reg <= 8'h00;
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (step_in && dir_in)
        cyl_reg <= cyl_reg + 8'h01;
      else if (step_in && cyl_reg != 8'h00)
        cyl_reg <= cyl_reg - 8'h01;
    end
  end
  // Sensor lines; a disabled track zero sensor never reports home
  assign ready_out  = rdy_en_in;
  assign fault_out  = flt_en_in;
  assign track0_out = trk0_en_in && (cyl_reg == 8'h00);
  assign tick_out   = (div_reg == 2'h3);
endmodule
